/* File: smst_blinker.sv */
// Free-running blink toggle, one shared by every LED that blinks.
// Assumes a synchronous active-high reset and a clock enable.
`timescale 1ns/10ps
`include "smst_defines.svh"
module smst_blinker (
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	output logic blink
);
	logic [24:0] count_q;

	// Half-period counter
	always_ff @(posedge clock) begin
		if (srst) begin
			count_q <= 25'h0000000;
			blink <= 1'b0;
		end else if (clkEn) begin
			if (count_q == 25'(`SMST_BLINK_CYC - 1)) begin
				count_q <= 25'h0000000;
				blink <= ~blink;
			end else begin
				count_q <= count_q + 25'h0000001;
			end
		end
	end
endmodule

/* File: smst_defines.svh */
// Constants for the sled management status and throttle block.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef SMST_DEFINES_SVH
`define SMST_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (word index on the plain software port)
// ---------------------------------------------------------------
`define SMST_REG_CTRL 4'h0
`define SMST_REG_STATUS 4'h1
`define SMST_REG_IRQ_STAT 4'h2
`define SMST_REG_IRQ_MASK 4'h3
`define SMST_REG_FAN_DUTY 4'h4
`define SMST_REG_POWER 4'h5
`define SMST_REG_POST_LAST 4'h6
`define SMST_REG_POST_CNT 4'h7
`define SMST_REG_POST_RD 4'h8
`define SMST_REG_CHASSIS 4'h9
`define SMST_REG_BAUD 4'ha
`define SMST_REG_LOG_PTR 4'hb

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SMST_CTRL_ALIVE 0
`define SMST_CTRL_IDENT 1
`define SMST_CTRL_FANOVR 2

// ---------------------------------------------------------------
// Interrupt status fields
// ---------------------------------------------------------------
`define SMST_IRQ_UC_ASSERT 0
`define SMST_IRQ_UC_DEASSERT 1
`define SMST_IRQ_FAN_FAIL 2
`define SMST_IRQ_POST 3
`define SMST_IRQ_W 4

// ---------------------------------------------------------------
// Reset values and thresholds (power in 0.1 W units)
// ---------------------------------------------------------------
`define SMST_FAN_FULL 8'hff
`define SMST_FAN_BOOST 8'hff
`define SMST_UC_ASSERT_DW 16'h156e
`define SMST_UC_DEASSERT_DW 16'h1192
`define SMST_BAUD_DEFAULT 32'h0001c200
`define SMST_POST_DEPTH 256
`define SMST_LOG_BYTES 65536

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SMST_CLK_HZ 125000000
`define SMST_BLINK_MS 250
`define SMST_BLINK_CYC ((`SMST_CLK_HZ / 1000) * `SMST_BLINK_MS)
`define SMST_PULSE_MS 1
`define SMST_PULSE_CYC ((`SMST_CLK_HZ / 1000) * `SMST_PULSE_MS)

`endif

/* File: smst_link_if.sv */
// Link between the management controller and the platform logic.
// Assumes both ends share one clock; no clocking block.
`timescale 1ns/10ps
interface smst_link_if;
	logic throttleNotify;
	logic hostPowerOn;
	logic hostResetReq;
	logic dcOn;
	logic [7:0] postCode;
	logic postValid;
	logic fanFail;
	logic [15:0] powerDw;
	logic powerValid;

	modport mgmt (
		output throttleNotify,
		output hostPowerOn,
		output hostResetReq,
		input dcOn,
		input postCode,
		input postValid,
		input fanFail,
		input powerDw,
		input powerValid
	);
	modport plat (
		input throttleNotify,
		input hostPowerOn,
		input hostResetReq,
		output dcOn,
		output postCode,
		output postValid,
		output fanFail,
		output powerDw,
		output powerValid
	);
endinterface

/* File: smst_link_monitor.sv */
// Checker for the link between the management and platform ends.
// Assumes one clock and srst; sees the link signals only.
`timescale 1ns/10ps
`include "smst_defines.svh"
module smst_link_monitor (
	input wire logic clock,
	input wire logic srst,
	input wire logic throttleNotify,
	input wire logic hostPowerOn,
	input wire logic hostResetReq,
	input wire logic dcOn,
	input wire logic [7:0] postCode,
	input wire logic postValid,
	input wire logic fanFail,
	input wire logic [15:0] powerDw,
	input wire logic powerValid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// ----
	// Throttle hysteresis
	// ----
	property p_thr_set;
		powerValid && powerDw >= `SMST_UC_ASSERT_DW |=> throttleNotify;
	endproperty
	a_thr_set: assert property (p_thr_set) else $error("throttle not raised");
	property p_thr_clr;
		powerValid && powerDw < `SMST_UC_DEASSERT_DW |=> !throttleNotify;
	endproperty
	a_thr_clr: assert property (p_thr_clr) else $error("throttle not dropped");
	property p_thr_mid;
		powerValid && powerDw >= `SMST_UC_DEASSERT_DW && powerDw < `SMST_UC_ASSERT_DW
			|=> $stable(throttleNotify);
	endproperty
	a_thr_mid: assert property (p_thr_mid) else $error("throttle moved in band");
	property p_thr_idle;
		!powerValid |=> $stable(throttleNotify);
	endproperty
	a_thr_idle: assert property (p_thr_idle) else $error("throttle moved unasked");
	property p_thr_rise;
		$rose(throttleNotify) |-> $past(powerDw) >= `SMST_UC_ASSERT_DW;
	endproperty
	a_thr_rise: assert property (p_thr_rise) else $error("throttle rose too low");
	property p_thr_fall;
		$fell(throttleNotify) |-> $past(powerDw) < `SMST_UC_DEASSERT_DW;
	endproperty
	a_thr_fall: assert property (p_thr_fall) else $error("throttle fell too high");

	// ----
	// Chassis control
	// ----
	property p_rst_len;
		$rose(hostResetReq) |-> hostResetReq [*8];
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset request too short");
	property p_rst_vals;
		$fell(srst) |-> hostPowerOn && !hostResetReq && !throttleNotify;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad link idle values");

	// Main scenarios reached
	c_post: cover property (postValid);
	c_up: cover property ($rose(throttleNotify));
	c_dn: cover property ($fell(throttleNotify));
	c_rst: cover property ($rose(hostResetReq));
	c_fan: cover property (fanFail);
endmodule

/* File: smst_mgmt.sv */
// Management controller end: self-test code capture, LEDs, fan drive,
// throttle hysteresis, chassis control and event log pointer.
// Assumes one clock; software on a plain strobe port.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "smst_defines.svh"
module smst_mgmt (
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	smst_link_if.mgmt link,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic sensorAlarm,
	output logic [7:0] postDisplay,
	output logic [7:0] fanDuty,
	output logic heartbeatLed,
	output logic powerLed,
	output logic stateLed,
	output logic irq
);
	// ---------------------------------------------------------------
	// Storage and control state
	// ---------------------------------------------------------------
	logic [7:0] postMem [0:`SMST_POST_DEPTH-1];
	logic [7:0] postWr_q;
	logic [8:0] postCnt_q;
	logic [7:0] postRdIdx_q;
	logic [2:0] ctrl_q;
	logic [7:0] fanSet_q;
	logic [`SMST_IRQ_W-1:0] irqStat_q;
	logic [`SMST_IRQ_W-1:0] irqMask_q;
	logic [`SMST_IRQ_W-1:0] irqEvt;
	logic [`SMST_IRQ_W-1:0] irqStat_d;
	logic [15:0] power_q;
	logic throttle_q;
	logic ucAssert;
	logic ucDeassert;
	logic [31:0] baud_q;
	logic [15:0] logPtr_q;
	smst_pkg::smst_state_t state_q;
	logic [16:0] pulseCnt_q;
	logic blink;
	logic [31:0] rd_d;

	smst_blinker u_blink (
		.clock(clock),
		.srst(srst),
		.clkEn(clkEn),
		.blink(blink)
	);

	// ---------------------------------------------------------------
	// Self-test code capture
	// ---------------------------------------------------------------
	// Ring memory, no reset needed; valid only below postCnt_q
	always_ff @(posedge clock) begin
		if (clkEn && link.postValid) begin
			postMem[postWr_q] <= link.postCode;
		end
	end

	// Write pointer and count run from the first cycle after reset
	always_ff @(posedge clock) begin
		if (srst) begin
			postWr_q <= 8'h00;
			postCnt_q <= 9'h000;
			postDisplay <= 8'h00;
		end else if (clkEn && link.postValid) begin
			postWr_q <= postWr_q + 8'h01;
			postDisplay <= link.postCode;
			if (postCnt_q != 9'(`SMST_POST_DEPTH)) begin
				postCnt_q <= postCnt_q + 9'h001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Software writes
	// ---------------------------------------------------------------
	// Plain control registers; every write acts on the next cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_q <= 3'h0;
			fanSet_q <= `SMST_FAN_FULL;
			irqMask_q <= '0;
			postRdIdx_q <= 8'h00;
			baud_q <= `SMST_BAUD_DEFAULT;
		end else if (clkEn && regWr) begin
			case (regAddr)
				`SMST_REG_CTRL: begin
					ctrl_q <= regWdata[2:0];
				end
				`SMST_REG_IRQ_MASK: begin
					irqMask_q <= regWdata[`SMST_IRQ_W-1:0];
				end
				`SMST_REG_FAN_DUTY: begin
					fanSet_q <= regWdata[7:0];
				end
				`SMST_REG_POST_RD: begin
					postRdIdx_q <= regWdata[7:0];
				end
				`SMST_REG_BAUD: begin
					baud_q <= regWdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Fan drive
	// ---------------------------------------------------------------
	// Full duty until software sets the override bit; failure wins
	always_ff @(posedge clock) begin
		if (srst) begin
			fanDuty <= `SMST_FAN_FULL;
		end else if (clkEn) begin
			if (link.fanFail) begin
				fanDuty <= `SMST_FAN_BOOST;
			end else if (ctrl_q[`SMST_CTRL_FANOVR]) begin
				fanDuty <= fanSet_q;
			end else begin
				fanDuty <= `SMST_FAN_FULL;
			end
		end
	end

	// ---------------------------------------------------------------
	// Power throttle with hysteresis
	// ---------------------------------------------------------------
	assign ucAssert = link.powerValid && !throttle_q && (link.powerDw >= `SMST_UC_ASSERT_DW);
	assign ucDeassert = link.powerValid && throttle_q && (link.powerDw < `SMST_UC_DEASSERT_DW);

	// Only crossings change the pin; the band between holds it
	always_ff @(posedge clock) begin
		if (srst) begin
			throttle_q <= 1'b0;
			power_q <= 16'h0000;
		end else if (clkEn) begin
			if (link.powerValid) begin
				power_q <= link.powerDw;
			end
			if (ucAssert) begin
				throttle_q <= 1'b1;
			end else if (ucDeassert) begin
				throttle_q <= 1'b0;
			end
		end
	end
	assign link.throttleNotify = throttle_q;

	// ---------------------------------------------------------------
	// Events, sticky status and interrupt
	// ---------------------------------------------------------------
	assign irqEvt = {link.postValid, link.fanFail, ucDeassert, ucAssert};

	// Set wins over a write-one clear in the same cycle
	assign irqStat_d = ((regWr && regAddr == `SMST_REG_IRQ_STAT) ?
		(irqStat_q & ~regWdata[`SMST_IRQ_W-1:0]) : irqStat_q) | irqEvt;

	// Interrupt follows the next status, so a clear drops it at once
	always_ff @(posedge clock) begin
		if (srst) begin
			irqStat_q <= '0;
			irq <= 1'b0;
		end else if (clkEn) begin
			irqStat_q <= irqStat_d;
			irq <= |(irqStat_d & irqMask_q);
		end
	end

	// Event log write pointer wraps in a 64K byte space, no alert logic
	always_ff @(posedge clock) begin
		if (srst) begin
			logPtr_q <= 16'h0000;
		end else if (clkEn && (ucAssert || ucDeassert)) begin
			logPtr_q <= logPtr_q + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Chassis control sequencer
	// ---------------------------------------------------------------
	// A cycle holds power off one pulse time before turning it back on
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= smst_pkg::SMST_ST_IDLE;
			pulseCnt_q <= 17'h00000;
		end else if (clkEn) begin
			case (state_q)
				smst_pkg::SMST_ST_IDLE,
				smst_pkg::SMST_ST_OFF,
				smst_pkg::SMST_ST_ON: begin
					if (regWr && regAddr == `SMST_REG_CHASSIS) begin
						pulseCnt_q <= 17'h00000;
						case (smst_pkg::smst_cmd_t'(regWdata[2:0]))
							smst_pkg::SMST_CMD_DOWN: state_q <= smst_pkg::SMST_ST_OFF;
							smst_pkg::SMST_CMD_UP: state_q <= smst_pkg::SMST_ST_ON;
							smst_pkg::SMST_CMD_CYCLE: state_q <= smst_pkg::SMST_ST_CYC_WAIT;
							smst_pkg::SMST_CMD_RESET: state_q <= smst_pkg::SMST_ST_RST;
							default: begin
							end
						endcase
					end
				end
				smst_pkg::SMST_ST_CYC_WAIT,
				smst_pkg::SMST_ST_RST: begin
					if (pulseCnt_q == 17'(`SMST_PULSE_CYC - 1)) begin
						state_q <= smst_pkg::SMST_ST_ON;
					end else begin
						pulseCnt_q <= pulseCnt_q + 17'h00001;
					end
				end
				default: begin
					state_q <= smst_pkg::SMST_ST_IDLE;
				end
			endcase
		end
	end

	// Link outputs registered; idle leaves host power on
	always_ff @(posedge clock) begin
		if (srst) begin
			link.hostPowerOn <= 1'b1;
			link.hostResetReq <= 1'b0;
		end else if (clkEn) begin
			link.hostPowerOn <= !(state_q == smst_pkg::SMST_ST_OFF ||
				state_q == smst_pkg::SMST_ST_CYC_WAIT);
			link.hostResetReq <= (state_q == smst_pkg::SMST_ST_RST);
		end
	end

	// ---------------------------------------------------------------
	// LEDs
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			heartbeatLed <= 1'b0;
			powerLed <= 1'b0;
			stateLed <= 1'b0;
		end else if (clkEn) begin
			heartbeatLed <= ctrl_q[`SMST_CTRL_ALIVE] & blink;
			powerLed <= ctrl_q[`SMST_CTRL_IDENT] ? blink : link.dcOn;
			stateLed <= sensorAlarm & blink;
		end
	end

	// ---------------------------------------------------------------
	// Register read, data one cycle after the strobe
	// ---------------------------------------------------------------
	always_comb begin
		rd_d = 32'h00000000;
		case (regAddr)
			`SMST_REG_CTRL: rd_d = {29'h0, ctrl_q};
			`SMST_REG_STATUS: rd_d = {28'h0, link.dcOn, link.fanFail, sensorAlarm, throttle_q};
			`SMST_REG_IRQ_STAT: rd_d = {28'h0, irqStat_q};
			`SMST_REG_IRQ_MASK: rd_d = {28'h0, irqMask_q};
			`SMST_REG_FAN_DUTY: rd_d = {16'h0, fanDuty, fanSet_q};
			`SMST_REG_POWER: rd_d = {16'h0, power_q};
			`SMST_REG_POST_LAST: rd_d = {24'h0, postDisplay};
			`SMST_REG_POST_CNT: rd_d = {15'h0, postCnt_q, postWr_q};
			`SMST_REG_POST_RD: rd_d = {16'h0, postRdIdx_q, postMem[postRdIdx_q]};
			`SMST_REG_CHASSIS: rd_d = {29'h0, state_q};
			`SMST_REG_BAUD: rd_d = baud_q;
			`SMST_REG_LOG_PTR: rd_d = {16'h0, logPtr_q};
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			regRdata <= 32'h00000000;
		end else if (clkEn) begin
			regRdata <= regRd ? rd_d : 32'h00000000;
		end
	end
endmodule

/* File: smst_pkg.sv */
// Types used by the management end of the sled management link.
// Assumes smst_defines.svh is used for every number.
package smst_pkg;
	// Chassis control commands
	typedef enum logic [2:0] {
		SMST_CMD_NONE = 3'b000,
		SMST_CMD_DOWN = 3'b001,
		SMST_CMD_UP = 3'b010,
		SMST_CMD_CYCLE = 3'b011,
		SMST_CMD_RESET = 3'b100
	} smst_cmd_t;

	// Chassis sequencer states
	typedef enum logic [2:0] {
		SMST_ST_IDLE = 3'b000,
		SMST_ST_OFF = 3'b001,
		SMST_ST_ON = 3'b010,
		SMST_ST_CYC_WAIT = 3'b011,
		SMST_ST_RST = 3'b100
	} smst_state_t;
endpackage

/* File: smst_plat.sv */
// Platform logic end: forwards codes, power readings and fan state
// to the management end; power-loss flush and card rail gating.
// Assumes one clock; user-side inputs synchronous.
`timescale 1ns/10ps
`include "smst_defines.svh"
module smst_plat (
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	smst_link_if.plat link,
	input wire logic [7:0] biosPostCode,
	input wire logic biosPostWr,
	input wire logic [15:0] powerReading,
	input wire logic powerSample,
	input wire logic fanFailIn,
	input wire logic dcOnIn,
	input wire logic acFail,
	input wire logic cardPresent,
	input wire logic [1:0] driveActive,
	output logic flushTrigger,
	output logic mainRail3vEn,
	output logic auxRail12vEn,
	output logic [1:0] driveLed,
	output logic hostThrottle,
	output logic hostPowerEn,
	output logic hostReset
);
	// ---------------------------------------------------------------
	// Link drive, registered
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			link.postCode <= 8'h00;
			link.postValid <= 1'b0;
			link.powerDw <= 16'h0000;
			link.powerValid <= 1'b0;
			link.fanFail <= 1'b0;
			link.dcOn <= 1'b0;
		end else if (clkEn) begin
			link.postCode <= biosPostCode;
			link.postValid <= biosPostWr;
			link.powerDw <= powerReading;
			link.powerValid <= powerSample;
			link.fanFail <= fanFailIn;
			link.dcOn <= dcOnIn;
		end
	end

	// ---------------------------------------------------------------
	// Platform outputs
	// ---------------------------------------------------------------
	// Rails drop one cycle after the card leaves
	always_ff @(posedge clock) begin
		if (srst) begin
			flushTrigger <= 1'b0;
			mainRail3vEn <= 1'b0;
			auxRail12vEn <= 1'b0;
			driveLed <= 2'h0;
			hostThrottle <= 1'b0;
			hostPowerEn <= 1'b0;
			hostReset <= 1'b0;
		end else if (clkEn) begin
			flushTrigger <= acFail;
			mainRail3vEn <= cardPresent;
			auxRail12vEn <= cardPresent;
			driveLed <= driveActive;
			hostThrottle <= link.throttleNotify;
			hostPowerEn <= link.hostPowerOn;
			hostReset <= link.hostResetReq;
		end
	end
endmodule

/* File: smst_testbench.sv */
// Self-checking bench: both ends joined by the link interface.
// Assumes the define constants; run stays near seven hundred cycles.
`timescale 1ns/10ps
`include "smst_defines.svh"
module testbench;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic clkEn = 1'b1;
	logic [31:0] regRdata;
	logic sensorAlarm = 1'b0;
	logic [7:0] postDisplay, fanDuty, biosPostCode = 8'h00;
	logic heartbeatLed, powerLed, stateLed, irq;
	logic biosPostWr = 1'b0, powerSample = 1'b0, fanFailIn = 1'b0, dcOnIn = 1'b0;
	logic acFail = 1'b0, cardPresent = 1'b0, rdSeen = 1'b0;
	logic [15:0] powerReading = 16'h0;
	logic [1:0] driveActive = 2'h0, driveLed;
	logic flushTrigger, mainRail3vEn, auxRail12vEn, hostThrottle, hostPowerEn, hostReset;
	logic [31:0] expQ[$], maskQ[$];
	logic [7:0] codes[256];
	logic [15:0] pw[7] = '{16'h1000, 16'h156d, 16'h156e, 16'h1200, 16'h1192, 16'h1191, 16'h1400};
	logic thrExp[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	int mismatches = 0;
	int num_checks = 0;
	int seedDummy;

	// Free-running 125 MHz clock
	always #4 clock = ~clock;

	smst_link_if link ();
	smst_mgmt u_smst_mgmt (.clock(clock), .srst(srst), .clkEn(clkEn), .link(link),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .sensorAlarm(sensorAlarm), .postDisplay(postDisplay),
		.fanDuty(fanDuty), .heartbeatLed(heartbeatLed), .powerLed(powerLed),
		.stateLed(stateLed), .irq(irq));
	smst_plat u_smst_plat (.clock(clock), .srst(srst), .clkEn(clkEn), .link(link),
		.biosPostCode(biosPostCode), .biosPostWr(biosPostWr), .powerReading(powerReading),
		.powerSample(powerSample), .fanFailIn(fanFailIn), .dcOnIn(dcOnIn), .acFail(acFail),
		.cardPresent(cardPresent), .driveActive(driveActive), .flushTrigger(flushTrigger),
		.mainRail3vEn(mainRail3vEn), .auxRail12vEn(auxRail12vEn), .driveLed(driveLed),
		.hostThrottle(hostThrottle), .hostPowerEn(hostPowerEn), .hostReset(hostReset));
	smst_link_monitor u_smst_link_monitor (.clock(clock), .srst(srst),
		.throttleNotify(link.throttleNotify), .hostPowerOn(link.hostPowerOn),
		.hostResetReq(link.hostResetReq), .dcOn(link.dcOn), .postCode(link.postCode),
		.postValid(link.postValid), .fanFail(link.fanFail), .powerDw(link.powerDw),
		.powerValid(link.powerValid));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Outputs are read 1 ns past the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// Expectation queued here, compared by the read watcher
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		maskQ.push_back(m);
		@(posedge clock);
		regRd <= 1'b0;
	endtask
	task automatic post(input logic [7:0] c);
		@(posedge clock);
		biosPostCode <= c;
		biosPostWr <= 1'b1;
		@(posedge clock);
		biosPostWr <= 1'b0;
	endtask
	task automatic pwr(input logic [15:0] p, input logic e);
		@(posedge clock);
		powerReading <= p;
		powerSample <= 1'b1;
		@(posedge clock);
		powerSample <= 1'b0;
		tick(4);
		chk(hostThrottle, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Read data stands one cycle after the strobe; compare it there
	always @(posedge clock) begin
		if (rdSeen && expQ.size() > 0)
			chk(regRdata & maskQ.pop_front(), expQ.pop_front());
		rdSeen <= regRd;
	end

	// Watchdog: the sequence needs about seven hundred cycles
	initial begin
		repeat (6000) @(posedge clock);
		mismatches++;
		complete_run();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		seedDummy = $urandom(5);
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		// Codes start on the first edge after release
		for (int i = 0; i < 256; i++) begin
			codes[i] = 8'($urandom);
			post(codes[i]);
		end
		tick(4);
		chk(postDisplay, codes[255]);
		// Clock enable low: a code offered now must leave no trace
		@(posedge clock);
		clkEn <= 1'b0;
		post(~codes[255]);
		@(posedge clock);
		clkEn <= 1'b1;
		tick(3);
		chk(postDisplay, codes[255]);
		wr(`SMST_REG_POST_RD, 32'h0);
		rd(`SMST_REG_POST_RD, {24'h0, codes[0]}, 32'hff);
		wr(`SMST_REG_POST_RD, 32'hff);
		rd(`SMST_REG_POST_RD, {24'h0, codes[255]}, 32'hff);
		rd(`SMST_REG_POST_CNT, 32'h00010000, 32'h0001ffff);
		rd(`SMST_REG_IRQ_STAT, 32'h8, 32'h8);
		tick(1);
		chk(irq, 1'b0);
		wr(`SMST_REG_IRQ_MASK, 32'h8);
		tick(3);
		chk(irq, 1'b1);
		wr(`SMST_REG_IRQ_STAT, 32'h8);
		tick(3);
		chk(irq, 1'b0);
		chk(fanDuty, `SMST_FAN_FULL);
		chk(heartbeatLed, 1'b0);
		rd(`SMST_REG_BAUD, `SMST_BAUD_DEFAULT, 32'hffffffff);
		rd(4'hf, 32'h0, 32'hffffffff);
		$display("test post done");
		foreach (pw[i]) pwr(pw[i], thrExp[i]);
		rd(`SMST_REG_IRQ_STAT, 32'h3, 32'h3);
		rd(`SMST_REG_LOG_PTR, 32'h2, 32'hffff);
		$display("test throttle done");
		wr(`SMST_REG_CTRL, 32'h4);
		wr(`SMST_REG_FAN_DUTY, 32'h40);
		tick(3);
		chk(fanDuty, 8'h40);
		@(posedge clock);
		fanFailIn <= 1'b1;
		tick(4);
		chk(fanDuty, `SMST_FAN_BOOST);
		rd(`SMST_REG_IRQ_STAT, 32'h4, 32'h4);
		$display("test fan done");
		@(posedge clock);
		dcOnIn <= 1'b1;
		sensorAlarm <= 1'b1;
		tick(4);
		chk(powerLed, 1'b1);
		// Identify overrides DC on; blink is still in its dark half here
		wr(`SMST_REG_CTRL, 32'h6);
		tick(3);
		chk(powerLed, 1'b0);
		wr(`SMST_REG_CTRL, 32'h4);
		rd(`SMST_REG_STATUS, 32'ha, 32'ha);
		@(posedge clock);
		dcOnIn <= 1'b0;
		sensorAlarm <= 1'b0;
		tick(4);
		chk(powerLed, 1'b0);
		chk(stateLed, 1'b0);
		// Platform glue, four input patterns; driveActive follows acFail and cardPresent
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			acFail <= i[0];
			cardPresent <= i[1];
			driveActive <= i[1:0];
			tick(3);
			chk(flushTrigger, i[0]);
			chk({mainRail3vEn, auxRail12vEn}, {2{i[1]}});
			chk(driveLed, i[1:0]);
		end
		$display("test leds done");
		wr(`SMST_REG_CHASSIS, 32'h1);
		tick(10);
		chk(hostPowerEn, 1'b0);
		rd(`SMST_REG_CHASSIS, 32'(smst_pkg::SMST_ST_OFF), 32'h7);
		wr(`SMST_REG_CHASSIS, 32'h2);
		tick(10);
		chk(hostPowerEn, 1'b1);
		wr(`SMST_REG_CHASSIS, 32'h3);
		tick(10);
		chk(hostPowerEn, 1'b0);
		// Cycle off time is long; a second reset cuts it short
		@(posedge clock);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		tick(4);
		chk(hostPowerEn, 1'b1);
		wr(`SMST_REG_CHASSIS, 32'h4);
		tick(12);
		chk(hostReset, 1'b1);
		$display("test chassis done");
		complete_run();
	end
endmodule
